// *** rtl/crxhs_top.sv ***
module crxhs_top import crxhs_pkg::*; (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	input  wire logic       linkClk,
	input  wire logic       linkHeaderValid,
	input  wire logic [7:0] linkHeaderByte,
	input  wire logic       clockLaneLpP,
	input  wire logic       clockLaneLpN
);

	localparam int PIN_COUNT = 12;

	typedef struct packed {
		logic           linkClkPrev;
		crxhs_lane_type lane;
		logic           laneFault;
		logic [1:0]     channel;
		logic [5:0]     dataType;
		logic [15:0]    wordCount;
		logic [5:0]     checkCode;
		logic           lineChanged;
		logic           inFrame;
		logic           havePrevCount;
		logic [15:0]    prevCount;
		logic           captureEnable;
		logic           lineCheckEnable;
		logic [7:0]     rdData;
	} crxhs_top_state_type;

	crxhs_top_state_type state;
	crxhs_top_state_type next_state;

	logic [PIN_COUNT-1:0] pinSync;
	logic                 syncLinkClk;
	logic                 syncValid;
	logic [7:0]           syncByte;
	logic [1:0]           syncLp;
	logic                 byteStrobe;
	logic                 hdrDone;
	logic [7:0]           hdrId;
	logic [15:0]          hdrCount;
	logic [7:0]           hdrCheck;
	logic                 hdrLong;
	logic                 hdrFrameStart;
	logic                 hdrFrameEnd;

	crxhs_sync #(
		.WIDTH (PIN_COUNT)
	) u_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.pinIn   ({linkClk, linkHeaderValid, linkHeaderByte,
		           clockLaneLpP, clockLaneLpN}),
		.pinSync (pinSync)
	);

	assign syncLinkClk = pinSync[11];
	assign syncValid   = pinSync[10];
	assign syncByte    = pinSync[9:2];
	assign syncLp      = pinSync[1:0];

	// Header bytes are taken on the rising link clock edge; the sender is
	// expected to move its data on the falling edge so both are stable.
	assign byteStrobe = syncLinkClk && !state.linkClkPrev;

	crxhs_hdr_cap u_hdr_cap (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.byteStrobe (byteStrobe),
		.byteValid  (syncValid),
		.byteIn     (syncByte),
		.hdrDone    (hdrDone),
		.hdrId      (hdrId),
		.hdrCount   (hdrCount),
		.hdrCheck   (hdrCheck)
	);

	assign hdrLong       = hdrDone && (hdrId[5:0] >= DT_LONG_MIN);
	assign hdrFrameStart = hdrDone && (hdrId[5:0] == DT_FRAME_START);
	assign hdrFrameEnd   = hdrDone && (hdrId[5:0] == DT_FRAME_END);

	always_comb begin
		next_state = state;
		next_state.linkClkPrev = syncLinkClk;

		// Clock lane low-power sequencing.
		case (state.lane)
			LANE_STOP: begin
				if (syncLp == LP_HS_REQ) begin
					next_state.lane = LANE_HS_REQUEST;
				end
			end
			LANE_HS_REQUEST: begin
				if (syncLp == LP_BRIDGE) begin
					next_state.lane = LANE_HIGH_SPEED;
					next_state.laneFault = 1'b0;
				end else if (syncLp != LP_HS_REQ) begin
					next_state.lane = LANE_STOP;
					next_state.laneFault = 1'b1;
				end
			end
			LANE_HIGH_SPEED: begin
				if (syncLp == LP_STOP) begin
					next_state.lane = LANE_STOP;
				end
			end
			default: begin
				next_state.lane = LANE_STOP;
			end
		endcase

		// Fields follow long headers only and hold otherwise.
		if (hdrLong && state.captureEnable) begin
			next_state.channel   = hdrId[7:6];
			next_state.dataType  = hdrId[5:0];
			next_state.wordCount = hdrCount;
			next_state.checkCode = hdrCheck[5:0];
		end

		// A new frame clears the change flag; a change seen later sets it.
		if (hdrFrameStart) begin
			next_state.inFrame = 1'b1;
			next_state.havePrevCount = 1'b0;
			next_state.lineChanged = 1'b0;
		end else if (hdrFrameEnd) begin
			next_state.inFrame = 1'b0;
		end else if (hdrLong && state.inFrame) begin
			next_state.havePrevCount = 1'b1;
			next_state.prevCount = hdrCount;
			if (state.lineCheckEnable && state.havePrevCount &&
			    hdrCount != state.prevCount) begin
				next_state.lineChanged = 1'b1;
			end
		end

		if (regWrite && regAddr == ADDR_BLOCK_CONTROL) begin
			next_state.captureEnable = regWrData[POS_CAPTURE_EN];
			next_state.lineCheckEnable = regWrData[POS_LINE_CHECK];
		end

		// Read data stands only in the cycle after the strobe.
		next_state.rdData = RESET_ZERO;
		if (regRead) begin
			case (regAddr)
				ADDR_CLOCK_LANE_ERROR_FLAGS: begin
					next_state.rdData[POS_LANE_FAULT] = state.laneFault;
				end
				ADDR_HEADER_CHANNEL_AND_TYPE: begin
					next_state.rdData = {state.channel, state.dataType};
				end
				ADDR_WORD_COUNT_LOW_BYTE: begin
					next_state.rdData = state.wordCount[7:0];
				end
				ADDR_WORD_COUNT_HIGH_BYTE: begin
					next_state.rdData = state.wordCount[15:8];
				end
				ADDR_HEADER_CHECK_BYTE_STATUS: begin
					next_state.rdData[5:0] = state.checkCode;
					next_state.rdData[POS_LINE_CHANGED] = state.lineChanged;
				end
				ADDR_BLOCK_CONTROL: begin
					next_state.rdData[POS_CAPTURE_EN] = state.captureEnable;
					next_state.rdData[POS_LINE_CHECK] = state.lineCheckEnable;
				end
				// Reserved locations show their reset value and ignore writes.
				ADDR_RSVD_72: begin
					next_state.rdData = RESET_RSVD_72;
				end
				ADDR_RSVD_7A: begin
					next_state.rdData = RESET_RSVD_7A;
				end
				ADDR_RSVD_86: begin
					next_state.rdData = RESET_RSVD_86;
				end
				ADDR_RSVD_90: begin
					next_state.rdData = RESET_RSVD_90;
				end
				default: begin
					next_state.rdData = RESET_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= '0;
			state.lane <= LANE_STOP;
			state.captureEnable <= RESET_CAPTURE_EN;
			state.lineCheckEnable <= RESET_LINE_CHECK;
		end else begin
			state <= next_state;
		end
	end

	assign regRdData = state.rdData;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_read(logic [7:0] addr);
		regRead && regAddr == addr;
	endsequence

	sequence s_hs_request_broken;
		state.lane == LANE_HS_REQUEST && syncLp != LP_HS_REQ &&
		syncLp != LP_BRIDGE;
	endsequence

	property p_lane_fault_set;
		s_hs_request_broken |=> state.laneFault && state.lane == LANE_STOP;
	endproperty
	a_lane_fault_set: assert property (p_lane_fault_set)
		else $error("clock lane fault not flagged");

	property p_lane_fault_read;
		s_read(ADDR_CLOCK_LANE_ERROR_FLAGS) |=>
			regRdData[POS_LANE_FAULT] == $past(state.laneFault) &&
			regRdData[7:2] == 6'h00 && !regRdData[0];
	endproperty
	a_lane_fault_read: assert property (p_lane_fault_read)
		else $error("clock lane error register read wrong");

	property p_channel_read;
		s_read(ADDR_HEADER_CHANNEL_AND_TYPE) |=>
			regRdData[7:6] == $past(state.channel);
	endproperty
	a_channel_read: assert property (p_channel_read)
		else $error("virtual channel read wrong");

	property p_type_read;
		s_read(ADDR_HEADER_CHANNEL_AND_TYPE) |=>
			regRdData[5:0] == $past(state.dataType);
	endproperty
	a_type_read: assert property (p_type_read)
		else $error("data type read wrong");

	property p_count_low;
		s_read(ADDR_WORD_COUNT_LOW_BYTE) |=>
			regRdData == $past(state.wordCount[7:0]);
	endproperty
	a_count_low: assert property (p_count_low)
		else $error("word count low byte wrong");

	property p_count_high;
		s_read(ADDR_WORD_COUNT_HIGH_BYTE) |=>
			regRdData == $past(state.wordCount[15:8]);
	endproperty
	a_count_high: assert property (p_count_high)
		else $error("word count high byte wrong");

	property p_line_change;
		hdrLong && state.inFrame && state.havePrevCount &&
		state.lineCheckEnable && hdrCount != state.prevCount
			|=> state.lineChanged [*2];
	endproperty
	a_line_change: assert property (p_line_change)
		else $error("line length change not flagged");

	property p_check_read;
		s_read(ADDR_HEADER_CHECK_BYTE_STATUS) |=>
			regRdData[5:0] == $past(state.checkCode) &&
			regRdData[POS_LINE_CHANGED] == $past(state.lineChanged) &&
			!regRdData[6];
	endproperty
	a_check_read: assert property (p_check_read)
		else $error("check byte status read wrong");

	property p_hold_fields;
		!(hdrLong && state.captureEnable) |=>
			$stable(state.channel) && $stable(state.dataType) &&
			$stable(state.wordCount) && $stable(state.checkCode);
	endproperty
	a_hold_fields: assert property (p_hold_fields)
		else $error("captured fields changed without a header");

	sequence s_long_taken;
		hdrLong && state.captureEnable;
	endsequence

	sequence s_hs_entry;
		state.lane == LANE_HS_REQUEST && syncLp == LP_BRIDGE;
	endsequence

	property p_channel_capture;
		s_long_taken |=> state.channel == $past(hdrId[7:6]);
	endproperty
	a_channel_capture: assert property (p_channel_capture)
		else $error("virtual channel not captured");

	property p_type_capture;
		s_long_taken |=> state.dataType == $past(hdrId[5:0]);
	endproperty
	a_type_capture: assert property (p_type_capture)
		else $error("data type not captured");

	property p_count_capture;
		s_long_taken |=> state.wordCount == $past(hdrCount);
	endproperty
	a_count_capture: assert property (p_count_capture)
		else $error("word count not captured");

	property p_check_capture;
		s_long_taken |=> state.checkCode == $past(hdrCheck[5:0]);
	endproperty
	a_check_capture: assert property (p_check_capture)
		else $error("check byte not captured");

	// Short packets pass through the same capture path, so guard them.
	property p_short_hold;
		hdrDone && !hdrLong |=> $stable(state.channel) &&
			$stable(state.dataType) && $stable(state.wordCount);
	endproperty
	a_short_hold: assert property (p_short_hold)
		else $error("short packet changed captured fields");

	property p_control_read;
		s_read(ADDR_BLOCK_CONTROL) |=> regRdData == {6'h00,
			$past(state.lineCheckEnable), $past(state.captureEnable)};
	endproperty
	a_control_read: assert property (p_control_read)
		else $error("block control read wrong");

	property p_lane_fault_clear;
		s_hs_entry |=> !state.laneFault && state.lane == LANE_HIGH_SPEED;
	endproperty
	a_lane_fault_clear: assert property (p_lane_fault_clear)
		else $error("clock lane fault not cleared on entry");

	property p_lane_fault_stay;
		state.laneFault && !(state.lane == LANE_HS_REQUEST &&
			syncLp == LP_BRIDGE) |=> state.laneFault;
	endproperty
	a_lane_fault_stay: assert property (p_lane_fault_stay)
		else $error("clock lane fault dropped early");

	property p_line_hold;
		state.lineChanged && !hdrFrameStart |=> state.lineChanged;
	endproperty
	a_line_hold: assert property (p_line_hold)
		else $error("line length flag dropped inside a frame");

	property p_line_clear;
		hdrFrameStart |=> !state.lineChanged && state.inFrame;
	endproperty
	a_line_clear: assert property (p_line_clear)
		else $error("frame start did not clear line flag");

	property p_frame_end;
		hdrFrameEnd |=> !state.inFrame;
	endproperty
	a_frame_end: assert property (p_frame_end)
		else $error("frame end not tracked");

endmodule

// *** pkg/crxhs_pkg.sv ***
// Function
// - Clock-lane fault flag in bit 1 when HS request sees a control error.
// - Header identifier register bits 7:6 show captured virtual channel, reset zero.
// - Header identifier register bits 5:0 show captured data type, reset zero.
// - Word count low byte register shows header payload count bits 7:0.
// - Word count high byte register shows header payload count bits 15:8.
// - Check byte status bit 7 flags a line length change within a frame.
// - Check byte status bits 5:0 show the header error-correction code.
package crxhs_pkg;

	localparam logic [7:0] ADDR_CLOCK_LANE_ERROR_FLAGS   = 8'h60;
	localparam logic [7:0] ADDR_HEADER_CHANNEL_AND_TYPE  = 8'h61;
	localparam logic [7:0] ADDR_WORD_COUNT_LOW_BYTE      = 8'h62;
	localparam logic [7:0] ADDR_WORD_COUNT_HIGH_BYTE     = 8'h63;
	localparam logic [7:0] ADDR_HEADER_CHECK_BYTE_STATUS = 8'h64;
	localparam logic [7:0] ADDR_BLOCK_CONTROL            = 8'hc0;

	localparam logic [7:0] ADDR_RSVD_72 = 8'h72;
	localparam logic [7:0] ADDR_RSVD_73 = 8'h73;
	localparam logic [7:0] ADDR_RSVD_74 = 8'h74;
	localparam logic [7:0] ADDR_RSVD_75 = 8'h75;
	localparam logic [7:0] ADDR_RSVD_76 = 8'h76;
	localparam logic [7:0] ADDR_RSVD_77 = 8'h77;
	localparam logic [7:0] ADDR_RSVD_78 = 8'h78;
	localparam logic [7:0] ADDR_RSVD_79 = 8'h79;
	localparam logic [7:0] ADDR_RSVD_7A = 8'h7a;
	localparam logic [7:0] ADDR_RSVD_86 = 8'h86;
	localparam logic [7:0] ADDR_RSVD_90 = 8'h90;
	localparam logic [7:0] RESET_RSVD_72 = 8'h25;
	localparam logic [7:0] RESET_RSVD_7A = 8'h04;
	localparam logic [7:0] RESET_RSVD_86 = 8'h90;
	localparam logic [7:0] RESET_RSVD_90 = 8'h32;
	localparam logic [7:0] RESET_ZERO    = 8'h00;

	localparam int POS_LANE_FAULT   = 1;
	localparam int POS_LINE_CHANGED = 7;
	localparam int POS_CAPTURE_EN   = 0;
	localparam int POS_LINE_CHECK   = 1;
	localparam logic RESET_CAPTURE_EN = 1'b1;
	localparam logic RESET_LINE_CHECK = 1'b1;

	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END   = 6'h01;
	localparam logic [5:0] DT_LONG_MIN    = 6'h10;

	// Low-power line pair {positive, negative} of the clock lane.
	localparam logic [1:0] LP_STOP     = 2'h3;
	localparam logic [1:0] LP_HS_REQ   = 2'h1;
	localparam logic [1:0] LP_BRIDGE   = 2'h0;

	typedef enum logic [1:0] {
		LANE_STOP,
		LANE_HS_REQUEST,
		LANE_HIGH_SPEED
	} crxhs_lane_type;

	typedef enum logic [1:0] {
		CAP_IDLE,
		CAP_GOT_ID,
		CAP_GOT_LOW,
		CAP_GOT_HIGH
	} crxhs_cap_type;

endpackage

// *** rtl/crxhs_sync.sv ***
module crxhs_sync import crxhs_pkg::*; #(
	parameter int WIDTH = 12
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} crxhs_sync_state_type;

	crxhs_sync_state_type state;
	crxhs_sync_state_type next_state;

	if (WIDTH < 1) begin : g_check
		$error("crxhs_sync needs WIDTH of at least one");
	end

	// The first stage feeds only the second stage.
	always_comb begin
		next_state.stage1 = pinIn;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pinSync = state.stage2;

endmodule

// *** rtl/crxhs_hdr_cap.sv ***
module crxhs_hdr_cap import crxhs_pkg::*; (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        byteStrobe,
	input  wire logic        byteValid,
	input  wire logic [7:0]  byteIn,
	output logic             hdrDone,
	output logic [7:0]       hdrId,
	output logic [15:0]      hdrCount,
	output logic [7:0]       hdrCheck
);

	typedef struct packed {
		crxhs_cap_type phase;
		logic          done;
		logic [7:0]    id;
		logic [15:0]   count;
		logic [7:0]    check;
	} crxhs_cap_state_type;

	crxhs_cap_state_type state;
	crxhs_cap_state_type next_state;

	// A header cut short by a drop of the valid line is discarded.
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (byteStrobe) begin
			if (!byteValid) begin
				next_state.phase = CAP_IDLE;
			end else begin
				case (state.phase)
					CAP_IDLE: begin
						next_state.id = byteIn;
						next_state.phase = CAP_GOT_ID;
					end
					CAP_GOT_ID: begin
						next_state.count[7:0] = byteIn;
						next_state.phase = CAP_GOT_LOW;
					end
					CAP_GOT_LOW: begin
						next_state.count[15:8] = byteIn;
						next_state.phase = CAP_GOT_HIGH;
					end
					CAP_GOT_HIGH: begin
						next_state.check = byteIn;
						next_state.done = 1'b1;
						next_state.phase = CAP_IDLE;
					end
					default: begin
						next_state.phase = CAP_IDLE;
					end
				endcase
			end
		end
		// The link clock stands still once a sender gives up, so a cut
		// header must be dropped on the valid line alone, not on a strobe.
		if (!byteValid) begin
			next_state.phase = CAP_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign hdrDone  = state.done;
	assign hdrId    = state.id;
	assign hdrCount = state.count;
	assign hdrCheck = state.check;

endmodule

// *** test/crxhs_sensor_model.sv ***
module crxhs_sensor_model (
	output logic       linkClk,
	output logic       linkHeaderValid,
	output logic [7:0] linkHeaderByte,
	output logic       clockLaneLpP,
	output logic       clockLaneLpN
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		linkClk = 1'b0;
		linkHeaderValid = 1'b0;
		linkHeaderByte = 8'h5a;
		clockLaneLpP = 1'b1;
		clockLaneLpN = 1'b1;
	end

	// The byte clock stands still between headers, like a gated clock lane.
	// A stall keeps the clock low mid-header to model a slow sender.
	task automatic send(input logic [31:0] hdr, input int n, input int stall);
		#7;
		for (int i = 0; i < n; i++) begin
			linkHeaderValid = 1'b1;
			linkHeaderByte = hdr[31-8*i -: 8];
			#160 linkClk = 1'b1;
			#160 linkClk = 1'b0;
			#(stall);
		end
		linkHeaderValid = 1'b0;
		// A released byte line must not keep showing the last byte.
		linkHeaderByte = ~linkHeaderByte;
	endtask

	task automatic lane(input logic [1:0] lp);
		{clockLaneLpP, clockLaneLpN} = lp;
		#400;
	endtask
endmodule

// *** test/crxhs_top_tb.sv ***
module crxhs_top_tb import crxhs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        reset;
	logic        regWrite;
	logic        regRead;
	logic        rdSeen = 1'b0;
	logic [7:0]  regAddr;
	logic [7:0]  regWrData;
	logic [7:0]  regRdData;
	logic [7:0]  id;
	logic [15:0] wc;
	logic [7:0]  ecc;
	logic [15:0] expQ[$];
	logic [15:0] note;
	wire logic   linkClk;
	wire logic   linkHeaderValid;
	wire logic [7:0] linkHeaderByte;
	wire logic   clockLaneLpP;
	wire logic   clockLaneLpN;
	int          fails = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          seed;
	logic [7:0]  tA[12] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h72,
		8'h73, 8'h7a, 8'h86, 8'h90, 8'h65, 8'hc0};
	logic [7:0]  tE[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h25,
		8'h00, 8'h04, 8'h90, 8'h32, 8'h00, 8'h03};

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	crxhs_top crxhs_top_i (
		.clk_sys        (clk_sys),
		.reset          (reset),
		.regAddr        (regAddr),
		.regWrData      (regWrData),
		.regWrite       (regWrite),
		.regRead        (regRead),
		.regRdData      (regRdData),
		.linkClk        (linkClk),
		.linkHeaderValid(linkHeaderValid),
		.linkHeaderByte (linkHeaderByte),
		.clockLaneLpP   (clockLaneLpP),
		.clockLaneLpN   (clockLaneLpN)
	);

	crxhs_sensor_model crxhs_sensor_model_i (
		.linkClk        (linkClk),
		.linkHeaderValid(linkHeaderValid),
		.linkHeaderByte (linkHeaderByte),
		.clockLaneLpP   (clockLaneLpP),
		.clockLaneLpN   (clockLaneLpN)
	);

	task automatic final_report();
		// Notes still queued mean a read whose data was never checked.
		if (expQ.size() != 0)
			fails++;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] exp, got, mask);
		cmp_count++;
		if ((got & mask) !== exp) begin
			fails++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic rd(input logic [7:0] a, e, input logic [7:0] m = 8'hff);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regWrite <= 1'b0;
		regAddr <= a;
		expQ.push_back({m, e & m});
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regRead <= 1'b0;
		regAddr <= a;
		regWrData <= d;
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			regRead <= 1'b0;
			regWrite <= 1'b0;
		end
	endtask

	task automatic hdr(input logic [7:0] i, input logic [15:0] w, input int st);
		crxhs_sensor_model_i.send({i, w[7:0], w[15:8], ecc}, 4, st);
	endtask

	always @(posedge clk_sys) begin
		rdSeen <= regRead;
		cycles++;
		if (cycles == 30000) begin
			fails++;
			final_report();
		end
	end

	// Read data stand only in the cycle after the strobe, so look mid-cycle.
	always @(negedge clk_sys) begin
		if (rdSeen === 1'b1) begin
			if (expQ.size() == 0) begin
				fails++;
				$display("[ERR] t=%0t exp=none got=%h", $time, regRdData);
			end else begin
				note = expQ.pop_front();
				check(note[7:0], regRdData, note[15:8]);
			end
		end
	end

	initial begin
		seed = 17;
		reset = 1'b1;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		idle(4);
		wr(ADDR_HEADER_CHANNEL_AND_TYPE, 8'($random(seed)));
		wr(ADDR_WORD_COUNT_HIGH_BYTE, 8'($random(seed)));
		for (int i = 0; i < 12; i++)
			rd(tA[i], tE[i]);
		idle(3);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			id = 8'($random(seed));
			id[4] = 1'b1;
			wc = 16'($random(seed));
			ecc = 8'($random(seed));
			hdr(8'($random(seed)) | 8'h10, 16'($random(seed)), 0);
			hdr(id, wc, (i % 2) * 900);
			hdr({id[7:6], DT_FRAME_END}, 16'h0000, 0);
			idle(10);
			rd(ADDR_HEADER_CHANNEL_AND_TYPE, id);
			rd(ADDR_WORD_COUNT_LOW_BYTE, wc[7:0]);
			rd(ADDR_WORD_COUNT_HIGH_BYTE, wc[15:8]);
			rd(ADDR_HEADER_CHECK_BYTE_STATUS, {2'b00, ecc[5:0]}, 8'h7f);
			idle(2);
		end
		ecc = 8'hff;
		crxhs_sensor_model_i.send({8'h2a, ~wc, 8'h11}, 3, 0);
		wr(ADDR_BLOCK_CONTROL, 8'h02);
		idle(1);
		hdr(8'h2b, ~wc, 0);
		idle(10);
		rd(ADDR_WORD_COUNT_LOW_BYTE, wc[7:0]);
		rd(ADDR_HEADER_CHANNEL_AND_TYPE, id);
		rd(ADDR_BLOCK_CONTROL, 8'h02);
		wr(ADDR_BLOCK_CONTROL, 8'h03);
		idle(2);
		$display("header hold done");
		ecc = 8'h2c;
		hdr(8'h6a, 16'h0100, 0);
		hdr(8'h40, 16'h0000, 0);
		hdr(8'h6a, 16'h0100, 0);
		hdr(8'h6a, 16'h0100, 0);
		idle(10);
		rd(ADDR_HEADER_CHECK_BYTE_STATUS, 8'h2c);
		idle(1);
		hdr(8'h6a, 16'h0101, 0);
		idle(10);
		rd(ADDR_HEADER_CHECK_BYTE_STATUS, 8'hac);
		rd(ADDR_WORD_COUNT_LOW_BYTE, 8'h01);
		idle(1);
		hdr(8'h40, 16'h0000, 0);
		idle(10);
		rd(ADDR_HEADER_CHECK_BYTE_STATUS, 8'h2c);
		idle(2);
		$display("line length done");
		for (int i = 0; i < 2; i++) begin
			crxhs_sensor_model_i.lane(LP_STOP);
			crxhs_sensor_model_i.lane(LP_HS_REQ);
			crxhs_sensor_model_i.lane(i == 0 ? 2'h2 : LP_STOP);
			rd(ADDR_CLOCK_LANE_ERROR_FLAGS, 8'h02);
			idle(1);
			crxhs_sensor_model_i.lane(LP_STOP);
			crxhs_sensor_model_i.lane(LP_HS_REQ);
			crxhs_sensor_model_i.lane(LP_BRIDGE);
			rd(ADDR_CLOCK_LANE_ERROR_FLAGS, 8'h00);
			idle(2);
			crxhs_sensor_model_i.lane(LP_STOP);
		end
		$display("clock lane done");
		idle(4);
		final_report();
	end
endmodule
